// ---- logic/vlhp_defs.vh ----
`ifndef VLHP_DEFS_VH
`define VLHP_DEFS_VH
`define VLHP_ADDR_W 18
`define VLHP_DATA_W 16
`define VLHP_SEL_REG 1'b0
`define VLHP_SEL_MEM 1'b1
`define VLHP_BLOCK_BYTES 262144
`define VLHP_RDY_SETTLE 2
`define VLHP_INTF_MODE_GENERIC2 3'h0
`endif

// ---- logic/vlhp_host_port.v ----
`timescale 1ns/1ps
`default_nettype none
`include "vlhp_defs.vh"
module vlhp_host_port #(
	parameter ADDR_W = `VLHP_ADDR_W,
	parameter DATA_W = `VLHP_DATA_W
) (
	input wire clk,
	input wire rstn,
	input wire [ADDR_W-1:0] host_addr_in,
	input wire [DATA_W-1:0] hostDataIn,
	output reg [DATA_W-1:0] hostDataOut,
	output wire hostDataOe,
	input wire chipSelectN,
	input wire readStrobeN,
	input wire write_strobe_n,
	input wire high_byte_enable_n,
	input wire memRegSelect,
	input wire bus_start_in_n,
	input wire readWriteDirN,
	input wire endian_strap,
	input wire hold_polarity_strap,
	input wire clock_divide_strap,
	output wire waitOut,
	output wire busClkEn,
	output reg reqValid,
	output reg reqWrite,
	output reg reqMem,
	output reg [ADDR_W-1:0] reqAddr,
	output reg [DATA_W-1:0] reqWdata,
	output reg [1:0] reqByteEn,
	input wire reqDone,
	input wire [DATA_W-1:0] reqRdata,
	output reg bigEndian,
	output reg unusedPinsBad
);
	localparam ST_IDLE = 2'h0;
	localparam ST_BUSY = 2'h1;
	localparam ST_HOLD = 2'h2;
	// IDLE waits for a fresh strobe, BUSY holds wait while the core arbitrates with
	// refresh, HOLD shows ready until the host drops its strobe. Only one access is in
	// flight at a time, which keeps the port free of any buffering.

	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg waitPol_r;
	reg clkDiv_r;
	reg divPhase_r;
	reg cfgDone_r;
	reg waitLevel;

	wire strobeN;
	wire strobeRise;
	wire strobeStable;
	wire [1:0] laneEn;

	// Byte lane enable from high byte enable and address bit 0.
	// An odd address always lands on the upper lane, and a word access needs the
	// high enable low on an even address.
	function [1:0] lane_decode;
		input hbN;
		input a0;
		begin
			if (!hbN && a0)
				lane_decode = 2'h2;
			else if (!hbN)
				lane_decode = 2'h3;
			else
				lane_decode = a0 ? 2'h2 : 2'h1;
		end
	endfunction

	// A strobe is a read or write low while selected; each new one is an access.
	assign strobeN = chipSelectN | (readStrobeN & write_strobe_n);
	assign laneEn = lane_decode(high_byte_enable_n, host_addr_in[0]);

	// The strobe passes two flops before use and a third only forms the edge. This costs
	// two cycles per access but keeps a metastable level on the strobe pins from reaching the state machine.
	vlhp_sync_edge uStrobe (
		.clk(clk),
		.rstn(rstn),
		.level(~strobeN),
		.risePulse(strobeRise),
		.stable(strobeStable)
	);

	// Straps are caught by a clocked process on the first edge after reset release.
	// Later strap movement is ignored, so a noisy strap cannot flip the bus mid-run.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cfgDone_r <= 1'b0;
			waitPol_r <= 1'b0;
			clkDiv_r <= 1'b0;
			bigEndian <= 1'b0;
		end else begin
			if (!cfgDone_r) begin
				cfgDone_r <= 1'b1;
				waitPol_r <= hold_polarity_strap;
				clkDiv_r <= clock_divide_strap;
				bigEndian <= endian_strap;
			end
		end
	end

	// Bus start and direction must sit high; a low level is flagged every clock.
	// It is a plain level rather than a sticky bit, so a mended strap clears it.
	always @(posedge clk or negedge rstn) begin
		if (!rstn)
			unusedPinsBad <= 1'b0;
		else
			unusedPinsBad <= ~(bus_start_in_n & readWriteDirN);
	end

	// Bus clock enable derived from the device clock, halved when strapped.
	// With the divide strap low the enable stays high and every edge is a bus edge.
	// A divided bus clock slows the core's answer, not the host's own timing.
	always @(posedge clk or negedge rstn) begin
		if (!rstn)
			divPhase_r <= 1'b0;
		else
			divPhase_r <= clkDiv_r ? ~divPhase_r : 1'b1;
	end
	assign busClkEn = divPhase_r;

	// A new strobe is only honoured once the straps are in, so an early access cannot
	// run with the wrong wait polarity.
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (strobeRise && cfgDone_r)
					state_nxt = ST_BUSY;
			end
			ST_BUSY: begin
				// A strobe dropped while busy still completes; arbitration cannot be aborted.
				if (reqDone)
					state_nxt = ST_HOLD;
			end
			ST_HOLD: begin
				// Ready holds until the host drops the strobe, so data stays valid.
				if (!strobeStable)
					state_nxt = ST_IDLE;
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	// The request is raised for one access and dropped on its done pulse; the fields stay
	// put until the next start, so the core may read them late.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= ST_IDLE;
			reqValid <= 1'b0;
			reqWrite <= 1'b0;
			reqMem <= `VLHP_SEL_REG;
			reqAddr <= {ADDR_W{1'b0}};
			reqWdata <= {DATA_W{1'b0}};
			reqByteEn <= 2'h0;
		end else begin
			state_r <= state_nxt;
			if (state_r == ST_IDLE && state_nxt == ST_BUSY) begin
				reqValid <= 1'b1;
				reqWrite <= ~write_strobe_n & readStrobeN;
				reqMem <= memRegSelect;
				reqAddr <= host_addr_in;
				reqWdata <= hostDataIn;
				reqByteEn <= laneEn;
			end else if (reqValid && reqDone) begin
				reqValid <= 1'b0;
			end
		end
	end

	// Read data is loaded once per access and left alone afterwards, so it stays valid
	// through the host's late capture however long the strobe is held.
	always @(posedge clk or negedge rstn) begin
		if (!rstn)
			hostDataOut <= {DATA_W{1'b0}};
		else if (reqValid && reqDone && !reqWrite)
			hostDataOut <= reqRdata;
	end

	// Wait stays asserted from strobe until data is ready or accepted; polarity strapped.
	// Before the straps are in, the pin follows the polarity strap itself, which is the
	// waiting level, so the host never sees a false ready just after reset.
	always @* begin
		waitLevel = waitPol_r;
		if (!cfgDone_r)
			waitLevel = hold_polarity_strap;
		else if (state_r == ST_HOLD)
			waitLevel = ~waitPol_r;
	end
	assign waitOut = waitLevel;
	// Read data drive is gated by select and read strobe only.
	assign hostDataOe = ~chipSelectN & ~readStrobeN;
endmodule
`default_nettype wire

// ---- logic/vlhp_sync_edge.v ----
`timescale 1ns/1ps
`default_nettype none
module vlhp_sync_edge (
	input wire clk,
	input wire rstn,
	input wire level,
	output wire risePulse,
	output wire stable
);
	reg stg1_r;
	reg stg2_r;
	reg stg3_r;
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			stg1_r <= 1'b0;
			stg2_r <= 1'b0;
			stg3_r <= 1'b0;
		end else begin
			stg1_r <= level;
			stg2_r <= stg1_r;
			stg3_r <= stg2_r;
		end
	end
	assign stable = stg2_r;
	assign risePulse = stg2_r & ~stg3_r;
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk = 0, rstn = 0, chipSelectN = 1, readStrobeN = 1, write_strobe_n = 1;
	logic high_byte_enable_n = 1, memRegSelect = 0, hostDataOe, waitOut, reqValid, reqWrite;
	logic reqMem, reqDone, bigEndian, unusedPinsBad, busClkEn;
	logic [17:0] host_addr_in = 0, reqAddr;
	logic [15:0] hostDataIn = 0, hostDataOut, reqWdata, reqRdata, q;
	logic [1:0] reqByteEn;
	logic [3:0] lag = 0;
	int fail_count = 0, checked = 0, n;
	always #4 clk = ~clk;
	vlhp_host_port vlhp_host_port_inst (.clk, .rstn, .host_addr_in, .hostDataIn, .hostDataOut,
		.hostDataOe, .chipSelectN, .readStrobeN, .write_strobe_n, .high_byte_enable_n,
		.memRegSelect, .bus_start_in_n(1'b1), .readWriteDirN(1'b1), .endian_strap(1'b0),
		.hold_polarity_strap(1'b1), .clock_divide_strap(1'b0), .waitOut, .busClkEn, .reqValid,
		.reqWrite, .reqMem, .reqAddr, .reqWdata, .reqByteEn, .reqDone, .reqRdata, .bigEndian,
		.unusedPinsBad);
	vlhp_core_model vlhp_core_model_inst (.clk, .rstn, .lag, .reqValid, .reqAddr, .reqDone,
		.reqRdata);
	task chk(input string s, input logic [17:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s exp %h seen %h", s, exp, seen);
		end
	endtask
	task acc(input logic w, input logic [17:0] a, input logic [15:0] d, input logic hb, m);
		int good;
		@(posedge clk);
		host_addr_in <= a;
		hostDataIn <= d;
		high_byte_enable_n <= hb;
		memRegSelect <= m;
		if (chipSelectN) begin
			chipSelectN <= 1'b0;
			repeat (2) @(posedge clk);
		end
		readStrobeN <= w;
		write_strobe_n <= !w;
		n = 0;
		good = 0;
		// Ready is sampled every half cycle and must be seen three times in a row, counting from a clock-high sample.
		while (good < 3 && n < 80) begin
			@(clk);
			#1;
			n++;
			good = (waitOut !== 1'b0) ? 0 : (good == 0 && clk == 1'b0) ? 0 : good + 1;
		end
		chk("ready", n < 80, 1);
		chk("drive", hostDataOe, !w);
		@(negedge clk);
		q = hostDataOut;
		@(posedge clk);
		readStrobeN <= 1'b1;
		write_strobe_n <= 1'b1;
		repeat (4) @(posedge clk);
		chk("float", hostDataOe, 0);
	endtask
	task t_cfg;
		chk("endian", bigEndian, 0);
		chk("pins", unusedPinsBad, 0);
		chk("bus clock", busClkEn, 1);
		chk("idle wait", waitOut, 1);
		$display("config done");
	endtask
	task t_lanes;
		logic [17:0] a;
		for (int i = 0; i < 4; i++) begin
			a = {16'h00A8, i[1:0]};
			acc(1'b0, a, 16'h0000, i[1], i[0]);
			chk("rdata", q, a[15:0] ^ 16'hA5C3);
			chk("lane", reqByteEn, i[0] ? 2'h2 : i[1] ? 2'h1 : 2'h3);
			chk("sel", reqMem, i[0]);
			chk("read", reqWrite, 0);
		end
		chipSelectN <= 1'b1;
		$display("lanes done");
	endtask
	task t_wr;
		for (int i = 0; i < 3; i++) begin
			acc(1'b1, 18'h3FFFF, {14'h3001, i[1:0]}, 1'b0, 1'b1);
			chk("wdata", reqWdata, {14'h3001, i[1:0]});
			chk("write", reqWrite, 1);
		end
		chipSelectN <= 1'b1;
		$display("writes done");
	endtask
	task t_slow;
		lag <= 4'hC;
		acc(1'b0, 18'h00010, 16'h0000, 1'b1, 1'b0);
		chk("stretch", n > 24, 1);
		lag <= 4'h0;
		chipSelectN <= 1'b1;
		$display("stretch done");
	endtask
	task wrap_up;
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		t_cfg;
		t_lanes;
		t_wr;
		t_slow;
		wrap_up;
	end
	initial begin
		#40000;
		fail_count++;
		wrap_up;
	end
endmodule
bind vlhp_host_port vlhp_host_port_asserts vlhp_host_port_asserts_inst (.clk, .rstn,
	.chipSelectN, .readStrobeN, .memRegSelect, .hold_polarity_strap, .hostDataOe, .waitOut,
	.reqValid, .reqMem, .reqDone);
`default_nettype wire

// ---- verification/vlhp_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module vlhp_core_model (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [3:0] lag,
	input wire logic reqValid,
	input wire logic [17:0] reqAddr,
	output logic reqDone,
	output logic [15:0] reqRdata
);
	logic [3:0] cnt;
	// The lag stands in for refresh arbitration holding the host off.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt <= 4'h0;
			reqDone <= 1'b0;
		end else begin
			reqDone <= reqValid && !reqDone && cnt == lag;
			cnt <= (reqValid && !reqDone) ? cnt + 4'h1 : 4'h0;
		end
	end
	assign reqRdata = reqAddr[15:0] ^ 16'hA5C3;
endmodule
`default_nettype wire

// ---- verification/vlhp_host_port_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module vlhp_host_port_asserts (
	input wire logic clk,
	input wire logic rstn,
	input wire logic chipSelectN,
	input wire logic readStrobeN,
	input wire logic memRegSelect,
	input wire logic hold_polarity_strap,
	input wire logic hostDataOe,
	input wire logic waitOut,
	input wire logic reqValid,
	input wire logic reqMem,
	input wire logic reqDone
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence sStart;
		$rose(reqValid);
	endsequence
	sequence sDone;
		reqValid && reqDone;
	endsequence
	AST_OE: assert property (hostDataOe == (!chipSelectN && !readStrobeN))
		else $error("bus drive");
	AST_BUSY: assert property (sStart |-> waitOut == hold_polarity_strap)
		else $error("no wait");
	AST_REL: assert property (sDone |=> !reqValid && waitOut != hold_polarity_strap ##1 !reqValid)
		else $error("no release");
	AST_HOLD: assert property (reqValid && !reqDone |=> reqValid)
		else $error("dropped");
	AST_CS: assert property (sStart |-> !chipSelectN)
		else $error("no select");
	AST_SEL: assert property (sStart |-> reqMem == memRegSelect)
		else $error("bad select");
	AST_RDY: assert property (waitOut != hold_polarity_strap |-> $past(reqDone) || $past(waitOut) != hold_polarity_strap)
		else $error("early ready");
	AST_QUIET: assert property (chipSelectN [*4] |-> !reqValid)
		else $error("stray");
endmodule
`default_nettype wire
